// >>> shared/dp_ram_pkg.sv
// Constants and types shared by the dual-port memory port logic.
// Assumes a single synchronous clock per port; no bus, plain pins only.
package dp_ram_pkg;

    // ========================================
    // Geometry
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned DATA_W = 9;
    localparam int unsigned DEPTH = 8192;
    localparam logic [12:0] ADDR_ZERO = 13'h0000;
    localparam logic [12:0] ADDR_STEP = 13'h0001;
    localparam logic [8:0] DATA_ZERO = 9'h000;

    // ========================================
    // Output mode select levels
    localparam logic MODE_FLOW = 1'b0;
    localparam logic MODE_PIPE = 1'b1;

    // ========================================
    // Cross-port timing, used by the far side only
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned WRITE_TO_READ_DELAY_NS = 40;
    localparam int unsigned PORT_CLOCK_SKEW_NS = 15;
    localparam int unsigned WRITE_TO_READ_CYCLES =
        (WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ========================================
    // Counter operation, one-hot
    typedef enum logic [3:0] {
        CNT_CLEAR = 4'h1,
        CNT_LOAD = 4'h2,
        CNT_HOLD = 4'h4,
        CNT_ADVANCE = 4'h8
    } cnt_op_t;

endpackage

// >>> core/dp_ram_array.sv
// Flip-flop storage array with one write port and one read port per side.
// Assumes both ports share ref_clk_i; write and read of both sides per cycle.
`timescale 1ns/10ps
`default_nettype none

module dp_ram_array #(
    parameter int unsigned AW = dp_ram_pkg::ADDR_W,
    parameter int unsigned DW = dp_ram_pkg::DATA_W
) (
    input wire logic ref_clk_i,
    input wire logic clk_en_i,
    input wire logic wr_en_a_i,
    input wire logic [AW-1:0] wr_addr_a_i,
    input wire logic [DW-1:0] wr_data_a_i,
    input wire logic [AW-1:0] rd_addr_a_i,
    output logic [DW-1:0] rd_data_a_o,
    input wire logic wr_en_b_i,
    input wire logic [AW-1:0] wr_addr_b_i,
    input wire logic [DW-1:0] wr_data_b_i,
    input wire logic [AW-1:0] rd_addr_b_i,
    output logic [DW-1:0] rd_data_b_o
);

    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // ========================================
    // Storage; port B wins a same-address collision.
    always_ff @(posedge ref_clk_i) begin
        if (clk_en_i && wr_en_a_i) begin
            mem_r[wr_addr_a_i] <= wr_data_a_i;
        end
        if (clk_en_i && wr_en_b_i) begin
            mem_r[wr_addr_b_i] <= wr_data_b_i;
        end
    end

    assign rd_data_a_o = mem_r[rd_addr_a_i];
    assign rd_data_b_o = mem_r[rd_addr_b_i];

endmodule

`default_nettype wire

// >>> core/dp_ram_port.sv
// Two ports of a synchronous dual-port static memory with address counters.
// Assumes both hosts run on ref_clk_i; data pins are split in/out/enable.
//
// Functional notes
// - All inputs sampled on rising edge except reset, output enable and mode select, which act at once.
// - Chip select inactive at an edge deselects the port and floats data pins.
// - Selected write stores pin data; selected read with output enable drives data.
// - Pipelined mode: chip-select change reaches outputs one clock later.
// - Pipelined read data arrives one cycle after flow-through, via output register.
// - Mode pin low gives flow-through, high gives pipelined.
// - Clear low at an edge sets counter to zero, overriding load and advance.
// - Clear high, load strobe low loads external address and accesses it.
// - Strobe, enable and clear all high hold counter and reuse previous address.
// - Strobe high, enable low, clear high advances counter by one.
// - Access address is pins while strobe low and clear high, counter while strobe high or clear low.
// - Counter works identically regardless of chip selects.
// - Counter clear costs no cycle; access may coincide with clear.
// - Counter advance works for writes and reads in both output modes.
// - Pipelined output state follows controls sampled the previous cycle.
// - Port selected only when low-active select low and high-active select high.
`timescale 1ns/10ps
`default_nettype none

module dp_ram_port #(
    parameter int unsigned AW = dp_ram_pkg::ADDR_W,
    parameter int unsigned DW = dp_ram_pkg::DATA_W
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic [1:0] output_mode_select_i,
    input wire logic [1:0] chip_select_low_active_n_i,
    input wire logic [1:0] chip_select_high_active_i,
    input wire logic [1:0] read_write_i,
    input wire logic [1:0] output_enable_n_i,
    input wire logic [1:0] address_load_strobe_n_i,
    input wire logic [1:0] counter_advance_enable_n_i,
    input wire logic [1:0] counter_clear_n_i,
    input wire logic [AW-1:0] addr_a_i,
    input wire logic [AW-1:0] addr_b_i,
    input wire logic [DW-1:0] data_a_i,
    input wire logic [DW-1:0] data_b_i,
    output logic [DW-1:0] data_a_o,
    output logic [DW-1:0] data_b_o,
    output logic [1:0] data_oe_o,
    output logic [AW-1:0] counter_a_o,
    output logic [AW-1:0] counter_b_o
);

    // ========================================
    // Counter decode
    function automatic dp_ram_pkg::cnt_op_t cnt_decode(input logic clr_n, input logic ads_n,
                                                       input logic cen_n);
        if (!clr_n) begin
            return dp_ram_pkg::CNT_CLEAR;
        end else if (!ads_n) begin
            return dp_ram_pkg::CNT_LOAD;
        end else if (cen_n) begin
            return dp_ram_pkg::CNT_HOLD;
        end
        return dp_ram_pkg::CNT_ADVANCE;
    endfunction

    function automatic logic [AW-1:0] cnt_next(input dp_ram_pkg::cnt_op_t op,
                                                input logic [AW-1:0] cur,
                                                input logic [AW-1:0] ext);
        logic [AW-1:0] res;
        res = cur;
        unique case (op)
            dp_ram_pkg::CNT_CLEAR: res = AW'(dp_ram_pkg::ADDR_ZERO);
            dp_ram_pkg::CNT_LOAD: res = ext;
            dp_ram_pkg::CNT_HOLD: res = cur;
            dp_ram_pkg::CNT_ADVANCE: res = cur + AW'(dp_ram_pkg::ADDR_STEP);
        endcase
        return res;
    endfunction

    // ========================================
    // Per-port input registers
    logic [AW-1:0] cnt_r [0:1];
    logic [AW-1:0] cnt_nxt [0:1];
    logic [AW-1:0] ext_addr [0:1];
    logic [DW-1:0] din [0:1];
    logic [DW-1:0] din_r [0:1];
    logic [1:0] sel;
    logic [1:0] sel_r;
    logic [1:0] wr_r;
    logic [1:0] sel_d_r;
    logic [1:0] rd_d_r;
    logic [AW-1:0] acc_addr_r [0:1];
    logic [DW-1:0] rd_data [0:1];
    logic [DW-1:0] pipe_r [0:1];
    logic [DW-1:0] dout [0:1];
    logic [1:0] drive;
    dp_ram_pkg::cnt_op_t op [0:1];

    assign ext_addr[0] = addr_a_i;
    assign ext_addr[1] = addr_b_i;
    assign din[0] = data_a_i;
    assign din[1] = data_b_i;

    for (genvar p = 0; p < 2; p++) begin : g_port
        // Selection needs both chip selects active together.
        assign sel[p] = !chip_select_low_active_n_i[p] && chip_select_high_active_i[p];
        assign op[p] = cnt_decode(counter_clear_n_i[p], address_load_strobe_n_i[p],
                                  counter_advance_enable_n_i[p]);
        // Counter runs independent of select; 13-bit sum wraps at the top.
        assign cnt_nxt[p] = cnt_next(op[p], cnt_r[p], ext_addr[p]);

        always_ff @(posedge ref_clk_i or posedge reset_i) begin
            if (reset_i) begin
                cnt_r[p] <= AW'(dp_ram_pkg::ADDR_ZERO);
                acc_addr_r[p] <= AW'(dp_ram_pkg::ADDR_ZERO);
                din_r[p] <= DW'(dp_ram_pkg::DATA_ZERO);
                sel_r[p] <= 1'b0;
                wr_r[p] <= 1'b0;
                sel_d_r[p] <= 1'b0;
                rd_d_r[p] <= 1'b0;
                pipe_r[p] <= DW'(dp_ram_pkg::DATA_ZERO);
            end else if (clk_en_i) begin
                // The accessed address is the new counter value, so clear and load
                // take effect in the same cycle with no dead cycle.
                cnt_r[p] <= cnt_nxt[p];
                acc_addr_r[p] <= cnt_nxt[p];
                din_r[p] <= din[p];
                sel_r[p] <= sel[p];
                wr_r[p] <= !read_write_i[p];
                sel_d_r[p] <= sel_r[p];
                rd_d_r[p] <= sel_r[p] && !wr_r[p];
                pipe_r[p] <= rd_data[p];
            end
        end

        // Flow-through drives array data; pipelined drives the output register.
        assign dout[p] = (output_mode_select_i[p] == dp_ram_pkg::MODE_PIPE) ? pipe_r[p]
                                                                             : rd_data[p];
        assign drive[p] = (output_mode_select_i[p] == dp_ram_pkg::MODE_PIPE)
                        ? (sel_d_r[p] && rd_d_r[p])
                        : (sel_r[p] && !wr_r[p]);
        // Output enable is asynchronous and only gates the drivers.
        assign data_oe_o[p] = drive[p] && !output_enable_n_i[p];
    end

    // ========================================
    // Storage
    dp_ram_array #(
        .AW(AW),
        .DW(DW)
    ) u_array (
        .ref_clk_i(ref_clk_i),
        .clk_en_i(clk_en_i),
        .wr_en_a_i(sel_r[0] && wr_r[0]),
        .wr_addr_a_i(acc_addr_r[0]),
        .wr_data_a_i(din_r[0]),
        .rd_addr_a_i(acc_addr_r[0]),
        .rd_data_a_o(rd_data[0]),
        .wr_en_b_i(sel_r[1] && wr_r[1]),
        .wr_addr_b_i(acc_addr_r[1]),
        .wr_data_b_i(din_r[1]),
        .rd_addr_b_i(acc_addr_r[1]),
        .rd_data_b_o(rd_data[1])
    );

    assign data_a_o = dout[0];
    assign data_b_o = dout[1];
    assign counter_a_o = cnt_r[0];
    assign counter_b_o = cnt_r[1];

    // ========================================
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    AST_CLEAR_ZERO: assert property (clk_en_i && !counter_clear_n_i[0]
        |=> counter_a_o == '0) else $error("Counter not cleared.");
    AST_LOAD: assert property (clk_en_i && counter_clear_n_i[0] && !address_load_strobe_n_i[0]
        |=> counter_a_o == $past(addr_a_i)) else $error("Address not loaded.");
    AST_HOLD: assert property (clk_en_i && (&{counter_clear_n_i[0], address_load_strobe_n_i[0],
        counter_advance_enable_n_i[0]}) |=> $stable(counter_a_o))
        else $error("Counter did not hold.");
    AST_ADVANCE: assert property (clk_en_i && counter_clear_n_i[0] &&
        address_load_strobe_n_i[0] && !counter_advance_enable_n_i[0]
        |=> counter_a_o == AW'($past(counter_a_o) + 1'b1))
        else $error("Counter did not advance.");
    AST_DESELECT: assert property (clk_en_i && chip_select_low_active_n_i[0]
        && output_mode_select_i[0] == dp_ram_pkg::MODE_FLOW
        ##1 output_mode_select_i[0] == dp_ram_pkg::MODE_FLOW |-> !data_oe_o[0])
        else $error("Deselected port drives.");
    AST_OE_ASYNC: assert property (output_enable_n_i[0] |-> !data_oe_o[0])
        else $error("Output enable ignored.");
    AST_PIPE_LAG: assert property (clk_en_i && output_mode_select_i[0] &&
        !chip_select_low_active_n_i[0] && chip_select_high_active_i[0] && read_write_i[0]
        ##1 clk_en_i ##1 output_mode_select_i[0] && !output_enable_n_i[0] |-> data_oe_o[0])
        else $error("Pipelined read not driven.");
    AST_FLOW_DRIVE: assert property (clk_en_i && output_mode_select_i[0] == 1'b0 &&
        !chip_select_low_active_n_i[0] && chip_select_high_active_i[0] && read_write_i[0]
        ##1 !output_mode_select_i[0] && !output_enable_n_i[0] |-> data_oe_o[0])
        else $error("Flow-through read not driven.");
    AST_CLR_ACCESS: assert property (clk_en_i && !counter_clear_n_i[0]
        |=> acc_addr_r[0] == '0) else $error("Clear access not at zero.");

    COV_PIPE_READ: cover property (output_mode_select_i[0] && data_oe_o[0]);
    COV_FLOW_READ: cover property (!output_mode_select_i[1] && data_oe_o[1]);
    COV_BURST_WRITE: cover property (wr_r[0] && sel_r[0] ##1 wr_r[0] && sel_r[0]);
    COV_CLEAR: cover property (!counter_clear_n_i[1]);

endmodule

`default_nettype wire

// >>> bench/host_b.sv
// Host model for port B: writes one word, then waits out the forwarding delay.
// Assumes the bench raises go_i for one cycle and changes it at the falling edge.
`timescale 1ns/10ps
`default_nettype none

module host_b (
    input wire logic ref_clk_i,
    input wire logic go_i,
    input wire logic [12:0] addr_i,
    input wire logic [8:0] data_i,
    output var logic sel_n_o = 1'h1,
    output var logic wr_o = 1'h0,
    output var logic [12:0] addr_o = 13'h0000,
    output var logic [8:0] data_o = 9'h000,
    output var logic done_o = 1'h0
);
    int wait_cnt = 0;

    // ========================================
    // Pins
    // Released pins show inverted values so stale data is never mistaken for valid.
    // Pins change by non-blocking assignment on the rising edge, after the port sampled them.
    always @(posedge ref_clk_i) begin
        done_o <= (wait_cnt == 1);
        if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
        sel_n_o <= !go_i;
        wr_o <= go_i;
        addr_o <= go_i ? addr_i : ~addr_o;
        data_o <= go_i ? data_i : ~data_o;
        if (go_i)
            wait_cnt <= dp_ram_pkg::WRITE_TO_READ_CYCLES + 2;
    end
endmodule

`default_nettype wire

// >>> bench/tb.sv
// Bench for the dual-port memory ports: a table of port A cycles, then edge cases.
// Assumes one shared clock; port B is worked by the host_b model.
`timescale 1ns/10ps
`default_nettype none

module tb;
    // Flags f: mode, select, read, load_n, advance_n, clear_n, check, enable.
    typedef struct packed {
        logic [7:0] f;
        logic [12:0] ad;
        logic [8:0] din;
        logic [12:0] cnt;
        logic [8:0] dat;
    } row_t;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic [5:0] a_ctl = 6'h00;
    logic a_csh = 1'h0;
    logic a_oe_n = 1'h0;
    logic [12:0] a_addr = 13'h0000;
    logic [8:0] a_din = 9'h000;
    logic b_go = 1'h0;
    logic b_sel_n, b_wr, b_done;
    logic [12:0] b_addr, counter_a;
    logic [8:0] b_data, data_a;
    logic [1:0] data_oe;
    int error_cnt = 0;
    int comparisons = 0;
    row_t rows [17] = '{
        '{8'h4e, 13'h0000, 9'h07e, 13'h0000, 9'h000}, '{8'h4e, 13'h0005, 9'h1a5, 13'h0005, 9'h000},
        '{8'h56, 13'h0000, 9'h0c3, 13'h0006, 9'h000}, '{8'h4e, 13'h1fff, 9'h155, 13'h1fff, 9'h000},
        '{8'h6f, 13'h0005, 9'h000, 13'h0005, 9'h1a5}, '{8'h77, 13'h0000, 9'h000, 13'h0006, 9'h0c3},
        '{8'h7f, 13'h0005, 9'h000, 13'h0006, 9'h0c3}, '{8'h63, 13'h0005, 9'h000, 13'h0000, 9'h07e},
        '{8'h2e, 13'h1fff, 9'h000, 13'h1fff, 9'h000}, '{8'h77, 13'h0000, 9'h000, 13'h0000, 9'h07e},
        '{8'hac, 13'h0005, 9'h000, 13'h0000, 9'h000}, '{8'hee, 13'h0005, 9'h000, 13'h0005, 9'h000},
        '{8'hf7, 13'h0000, 9'h000, 13'h0006, 9'h1a5}, '{8'hbf, 13'h0000, 9'h000, 13'h0006, 9'h0c3},
        '{8'hd6, 13'h0000, 9'h0aa, 13'h0007, 9'h000}, '{8'hee, 13'h0007, 9'h000, 13'h0007, 9'h000},
        '{8'hff, 13'h0000, 9'h000, 13'h0007, 9'h0aa}};

    always #50 ref_clk = !ref_clk;

    host_b host_b_inst (.ref_clk_i(ref_clk), .go_i(b_go), .addr_i(13'h0009), .data_i(9'h111),
        .sel_n_o(b_sel_n), .wr_o(b_wr), .addr_o(b_addr), .data_o(b_data), .done_o(b_done));

    dp_ram_port dp_ram_port_inst (.ref_clk_i(ref_clk), .reset_i(reset), .clk_en_i(1'h1),
        .output_mode_select_i({1'h0, a_ctl[5]}), .chip_select_low_active_n_i({b_sel_n, !a_ctl[4]}),
        .chip_select_high_active_i({1'h1, a_csh}), .read_write_i({!b_wr, a_ctl[3]}),
        .output_enable_n_i({1'h1, a_oe_n}), .address_load_strobe_n_i({1'h0, a_ctl[2]}),
        .counter_advance_enable_n_i({1'h1, a_ctl[1]}), .counter_clear_n_i({1'h1, a_ctl[0]}),
        .addr_a_i(a_addr), .addr_b_i(b_addr), .data_a_i(a_din), .data_b_i(b_data),
        .data_a_o(data_a), .data_b_o(), .data_oe_o(data_oe), .counter_a_o(counter_a),
        .counter_b_o());

    task automatic check(input string nm, input logic [12:0] got, input logic [12:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apply(input row_t r);
        @(negedge ref_clk);
        a_ctl = r.f[7:2];
        a_csh = r.f[6];
        a_addr = r.ad;
        a_din = r.din;
    endtask

    task automatic give_verdict;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        repeat (16) @(negedge ref_clk);
        reset = 1'h0;
        check("counter", counter_a, 13'h0000);
        check("enable", {12'h000, data_oe[0]}, 13'h0000);
        $display("reset test done");
        foreach (rows[i]) begin
            apply(rows[i]);
            @(posedge ref_clk);
            #10;
            if (rows[i].f[1]) begin
                check("counter", counter_a, rows[i].cnt);
                check("enable", {12'h000, data_oe[0]}, {12'h000, rows[i].f[0]});
                if (rows[i].f[0])
                    check("data", {4'h0, data_a}, {4'h0, rows[i].dat});
            end
        end
        $display("table test done");
        @(negedge ref_clk);
        a_oe_n = 1'h1;
        #5;
        check("enable", {12'h000, data_oe[0]}, 13'h0000);
        a_oe_n = 1'h0;
        #5;
        check("enable", {12'h000, data_oe[0]}, 13'h0001);
        $display("output enable test done");
        @(negedge ref_clk);
        a_ctl = 6'h1b;
        a_csh = 1'h0;
        a_addr = 13'h0005;
        @(posedge ref_clk);
        #10;
        check("enable", {12'h000, data_oe[0]}, 13'h0000);
        @(negedge ref_clk);
        a_csh = 1'h1;
        @(posedge ref_clk);
        #10;
        check("data", {4'h0, data_a}, 13'h01a5);
        $display("select test done");
        @(negedge ref_clk);
        b_go = 1'h1;
        @(negedge ref_clk);
        b_go = 1'h0;
        for (int n = 0; n < 10 && !b_done; n++)
            @(negedge ref_clk);
        if (b_done !== 1'h1) begin
            error_cnt++;
        end else begin
            apply('{8'h6f, 13'h0009, 9'h000, 13'h0000, 9'h000});
            @(posedge ref_clk);
            #10;
            check("data", {4'h0, data_a}, 13'h0111);
        end
        $display("cross port test done");
        give_verdict();
    end
endmodule

`default_nettype wire
